/* rtl/boost_cfg_pkg.sv */
// Purpose: Shared constants and types for the boost regulator settings bank.
// Assumes: A byte-wide register port and a 100 MHz core clock.
// Notes: The decode tables map each field code to its physical figure.
package boost_cfg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] start_voltage_addr = 8'h73;
  localparam logic [7:0] loop_comp_addr = 8'h74;
  localparam logic [7:0] switch_timing_addr = 8'h75;

  // Values loaded at reset, before the nonvolatile copy is written in.
  localparam logic [7:0] start_voltage_reset = 8'h00;
  localparam logic [7:0] loop_comp_reset = 8'h00;
  localparam logic [7:0] switch_timing_reset = 8'h00;

  // Bits that hold a value; all others read as zero.
  localparam logic [7:0] start_voltage_mask = 8'h3f;
  localparam logic [7:0] loop_comp_mask = 8'hff;
  localparam logic [7:0] switch_timing_mask = 8'hf7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int start_code_lsb = 0;
  localparam int light_load_lsb = 6;
  localparam int jitter_lsb = 4;
  localparam int integral_lsb = 2;
  localparam int proportional_lsb = 0;
  localparam int off_time_lsb = 6;
  localparam int blank_time_lsb = 4;
  localparam int ramp_rate_lsb = 0;

  // ****************************************
  // Figures
  // ****************************************
  localparam logic [15:0] target_base_mv = 16'd16000;
  localparam logic [15:0] target_step_mv = 16'd500;
  localparam logic [5:0] target_code_max = 6'h3f;
  localparam logic [4:0] light_load_step_ua = 5'd5;
  localparam logic [4:0] ramp_count_max = 5'd16;

  typedef struct packed {
    logic [4:0] light_load_ua;
    logic jitter_bypass;
    logic [8:0] jitter_corner_khz;
    logic [2:0] integral_factor;
    logic [2:0] proportional_factor;
  } loop_cfg_t;

  typedef struct packed {
    logic [7:0] off_time_ns;
    logic [7:0] blank_time_ns;
    logic [4:0] ramp_cycles;
  } timing_cfg_t;

  typedef struct packed {
    logic [5:0] target_code;
    logic [15:0] target_mv;
    logic adaptive_active;
  } target_t;

  function automatic logic [4:0] ramp_cycles_of(input logic [2:0] code);
    case (code)
      3'h6: ramp_cycles_of = 5'd8;
      3'h7: ramp_cycles_of = ramp_count_max;
      default: ramp_cycles_of = {2'h0, code} + 5'd1;
    endcase
  endfunction

  function automatic logic [8:0] jitter_khz_of(input logic [1:0] code);
    case (code)
      2'h1: jitter_khz_of = 9'd300;
      2'h2: jitter_khz_of = 9'd60;
      2'h3: jitter_khz_of = 9'd30;
      default: jitter_khz_of = 9'd0;
    endcase
  endfunction

  function automatic logic [7:0] off_ns_of(input logic [1:0] code);
    case (code)
      2'h0: off_ns_of = 8'd131;
      2'h1: off_ns_of = 8'd68;
      2'h2: off_ns_of = 8'd38;
      default: off_ns_of = 8'd24;
    endcase
  endfunction

  function automatic logic [7:0] blank_ns_of(input logic [1:0] code);
    case (code)
      2'h0: blank_ns_of = 8'd162;
      2'h1: blank_ns_of = 8'd88;
      2'h2: blank_ns_of = 8'd63;
      default: blank_ns_of = 8'd40;
    endcase
  endfunction

  function automatic logic [2:0] factor_of(input logic [1:0] code);
    factor_of = {1'b0, code} + 3'd1;
  endfunction

endpackage

/* rtl/ramp_pacer.sv */
// Purpose: Grants one target step every N dimming cycles.
// Assumes: dim_cycle_i is a one-cycle pulse from logic on the same clock.
// Notes: Count restarts when the rate changes so no step comes early.
`timescale 1ns/1ns
module ramp_pacer
  import boost_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [4:0] cycles_i,
  input wire logic dim_cycle_i,
  output logic step_ok_o
);

  logic [4:0] count_q;
  logic [4:0] count_d;
  logic [4:0] cycles_q;
  logic [4:0] cycles_d;
  logic step_ok_q;
  logic step_ok_d;

  always_comb begin
    count_d = count_q;
    cycles_d = cycles_i;
    step_ok_d = 1'b0;
    if (cycles_i != cycles_q) begin
      count_d = 5'd0;
    end else if (dim_cycle_i) begin
      if (count_q + 5'd1 >= cycles_i) begin
        count_d = 5'd0;
        step_ok_d = 1'b1;
      end else begin
        count_d = count_q + 5'd1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_q <= 5'd0;
      cycles_q <= 5'd1;
      step_ok_q <= 1'b0;
    end else if (clk_en_i) begin
      count_q <= count_d;
      cycles_q <= cycles_d;
      step_ok_q <= step_ok_d;
    end
  end

  assign step_ok_o = step_ok_q;

endmodule

/* rtl/boost_regulator_config_regs.sv */
// Purpose: Three boost regulator settings registers and the voltage target.
// Assumes: The serial host port presents decoded byte reads and writes.
// Notes: Analog loop behaviour lives elsewhere; this block hands it figures.
//
// Notes on behaviour
// - The start code n stands for 16.0 V plus 0.5 V times n.
// - With adaptive control on, the start code only seeds the target.
// - With adaptive control off, the target is held at the start code.
// - Bits 7:6 of the loop register pick a light-load current in steps.
// - Jitter code 00 bypasses, 01/10/11 give 300, 60 and 30 kHz.
// - The integral factor is bits 3:2 plus one.
// - The proportional factor is bits 1:0 plus one.
// - Off-time codes give 131, 68, 38 and 24 ns.
// - Blanking codes give 162, 88, 63 and 40 ns.
// - The target steps once every 1,2,3,4,5,6,8 or 16 dimming cycles.
// - Every field is readable and writable by the host.
// - The adaptive enable picks the mode, forced off in all-cluster mode.
`timescale 1ns/1ns
module boost_regulator_config_regs
  import boost_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  input wire logic adaptive_voltage_enable_i,
  input wire logic all_cluster_mode_i,
  input wire logic startup_i,
  input wire logic dim_cycle_i,
  input wire logic raise_req_i,
  input wire logic lower_req_i,
  output loop_cfg_t loop_cfg_o,
  output timing_cfg_t timing_cfg_o,
  output target_t target_o
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] start_q;
  logic [7:0] start_d;
  logic [7:0] loop_q;
  logic [7:0] loop_d;
  logic [7:0] timing_q;
  logic [7:0] timing_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic hit;
  logic [7:0] rsel;
  logic [1:0] index;

  // ****************************************
  // Address decode
  // ****************************************
  // One decode serves the read mux and the write strobes, so the two can
  // never disagree about which byte an address names.
  function automatic logic [1:0] index_of(input logic [7:0] addr);
    case (addr)
      start_voltage_addr: index_of = 2'h0;
      loop_comp_addr: index_of = 2'h1;
      switch_timing_addr: index_of = 2'h2;
      default: index_of = 2'h3;
    endcase
  endfunction

  // Reserved bits are cleared on the way in, so they also read back as zero.
  function automatic logic [7:0] masked(input logic [1:0] idx,
                                        input logic [7:0] data);
    case (idx)
      2'h0: masked = data & start_voltage_mask;
      2'h1: masked = data & loop_comp_mask;
      2'h2: masked = data & switch_timing_mask;
      default: masked = 8'h00;
    endcase
  endfunction

  always_comb begin
    start_d = start_q;
    loop_d = loop_q;
    timing_d = timing_q;
    index = index_of(reg_addr_i);
    hit = (index != 2'h3);
    case (index)
      2'h0: rsel = start_q;
      2'h1: rsel = loop_q;
      2'h2: rsel = timing_q;
      default: rsel = 8'h00;
    endcase
    if (reg_wr_i) begin
      case (index)
        2'h0: start_d = masked(index, reg_wdata_i);
        2'h1: loop_d = masked(index, reg_wdata_i);
        2'h2: timing_d = masked(index, reg_wdata_i);
        default: ;
      endcase
    end
    // Read data holds until the next read, so a slow host may fetch it late.
    rdata_d = reg_rd_i ? rsel : rdata_q;
  end

  // A low clock enable freezes the bank, host strobes included.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      start_q <= start_voltage_reset;
      loop_q <= loop_comp_reset;
      timing_q <= switch_timing_reset;
      rdata_q <= 8'h00;
    end else if (clk_en_i) begin
      start_q <= start_d;
      loop_q <= loop_d;
      timing_q <= timing_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_hit_o = hit;

  // ****************************************
  // Field decode
  // ****************************************
  // Decoded figures are registered so the analog side sees glitch-free values.
  // Each loop and timing field is decoded once here and only its figures leave the block.
  loop_cfg_t loop_cfg_q;
  loop_cfg_t loop_cfg_d;
  timing_cfg_t timing_cfg_q;
  timing_cfg_t timing_cfg_d;
  logic [1:0] llc_code;
  logic [1:0] jit_code;

  always_comb begin
    llc_code = loop_q[light_load_lsb +: 2];
    jit_code = loop_q[jitter_lsb +: 2];
    loop_cfg_d.light_load_ua = light_load_step_ua * ({3'h0, llc_code} + 5'd1);
    loop_cfg_d.jitter_bypass = (jit_code == 2'h0);
    loop_cfg_d.jitter_corner_khz = jitter_khz_of(jit_code);
    loop_cfg_d.integral_factor = factor_of(loop_q[integral_lsb +: 2]);
    loop_cfg_d.proportional_factor =
      factor_of(loop_q[proportional_lsb +: 2]);
    timing_cfg_d.off_time_ns = off_ns_of(timing_q[off_time_lsb +: 2]);
    timing_cfg_d.blank_time_ns =
      blank_ns_of(timing_q[blank_time_lsb +: 2]);
    timing_cfg_d.ramp_cycles =
      ramp_cycles_of(timing_q[ramp_rate_lsb +: 3]);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      loop_cfg_q <= '0;
      timing_cfg_q <= '0;
    end else if (clk_en_i) begin
      loop_cfg_q <= loop_cfg_d;
      timing_cfg_q <= timing_cfg_d;
    end
  end

  assign loop_cfg_o = loop_cfg_q;
  assign timing_cfg_o = timing_cfg_q;

  // ****************************************
  // Regulator target
  // ****************************************
  logic step_ok;
  logic adaptive_active;
  logic [5:0] start_code;
  target_t target_q;
  target_t target_d;

  // The pacer grant is dropped unless adaptive control is active, so the
  // fixed mode never drifts away from the start code.
  ramp_pacer u_pacer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .cycles_i(timing_cfg_q.ramp_cycles),
    .dim_cycle_i(dim_cycle_i),
    .step_ok_o(step_ok)
  );

  always_comb begin
    adaptive_active = adaptive_voltage_enable_i & ~all_cluster_mode_i;
    start_code = start_q[start_code_lsb +: 6];
    target_d = target_q;
    target_d.adaptive_active = adaptive_active;
    // The start code wins whenever adaptive control is off or the regulator
    // restarts, so a cold start never inherits a stale adapted level.
    if (!adaptive_active || startup_i) begin
      target_d.target_code = start_code;
    end else if (step_ok) begin
      // Raise wins over lower below the top code; at the top code a lower request still steps down.
      if (raise_req_i && target_q.target_code != target_code_max) begin
        target_d.target_code = target_q.target_code + 6'd1;
      end else if (lower_req_i && target_q.target_code != 6'h00) begin
        target_d.target_code = target_q.target_code - 6'd1;
      end
    end
    target_d.target_mv = target_base_mv +
      target_step_mv * {10'h000, target_d.target_code};
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      target_q.target_code <= start_voltage_reset[5:0];
      target_q.target_mv <= target_base_mv;
      target_q.adaptive_active <= 1'b0;
    end else if (clk_en_i) begin
      target_q <= target_d;
    end
  end

  assign target_o = target_q;

endmodule

/* verif/boost_regulator_config_regs_assertions.sv */
// Purpose: Port checks for the boost settings bank.
// Assumes: One clock; bound from the bench top file.
// Notes: Decode is checked after two quiet edges, to allow for latency.
`timescale 1ns/1ns
module boost_regulator_config_regs_assertions
  import boost_cfg_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  input wire logic adaptive_voltage_enable_i,
  input wire logic all_cluster_mode_i,
  input wire loop_cfg_t loop_cfg_o,
  input wire target_t target_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic rd_en;
  assign rd_en = clk_en_i && reg_rd_i;
  function automatic logic [2:0] fac(input logic [7:0] w, input int lsb);
    return {1'b0, w[lsb+:2]} + 3'd1;
  endfunction
  a_hit_decode: assert property (
    reg_hit_o == (reg_addr_i inside {8'h73, 8'h74, 8'h75})) else $error("hit");
  a_unmapped_zero: assert property (
    rd_en && !reg_hit_o |=> reg_rdata_o == 8'h00) else $error("unmapped");
  a_start_reserved: assert property (
    rd_en && reg_addr_i == 8'h73 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("start reserved");
  a_timing_reserved: assert property (
    rd_en && reg_addr_i == 8'h75 |=> !reg_rdata_o[3]) else $error("bit 3");
  a_target_volts: assert property (
    target_o.target_mv == 16'd16000 + 16'd500 * {10'h0, target_o.target_code})
    else $error("volts");
  a_cluster_off: assert property (
    clk_en_i && (all_cluster_mode_i || !adaptive_voltage_enable_i)
    |=> !target_o.adaptive_active) else $error("adaptive on");
  a_fixed_hold: assert property (
    (!target_o.adaptive_active && !reg_wr_i) [*3]
    |=> $stable(target_o.target_code)) else $error("target moved");
  a_loop_decode: assert property (
    clk_en_i && reg_wr_i && reg_addr_i == 8'h74 ##1
    (clk_en_i && !reg_wr_i) [*2] |=>
    loop_cfg_o.integral_factor == fac($past(reg_wdata_i, 3), 2) &&
    loop_cfg_o.proportional_factor == fac($past(reg_wdata_i, 3), 0) &&
    loop_cfg_o.light_load_ua == 5'd5 * {2'h0, fac($past(reg_wdata_i, 3), 6)})
    else $error("loop decode");
endmodule

/* verif/host_model.sv */
// Purpose: Host side of the settings register port.
// Assumes: A strobe is taken on the rising edge after it is raised.
// Notes: Released address and data lines show the inverse, so stale values are never trusted.
`timescale 1ns/1ns
module host_model (
  input wire logic clock_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  task automatic access(input logic [7:0] a, input logic [7:0] d,
                        input logic w, output logic [7:0] q);
    @(posedge clock_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(posedge clock_i);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    q = reg_rdata_i;
  endtask
endmodule

/* verif/boost_regulator_config_regs_tb.sv */
// Purpose: Self-checking bench for the boost settings bank.
// Assumes: Inputs change 1 ns after each rising edge.
// Notes: Table rows cover readback; decode and target cases follow.
`timescale 1ns/1ns
module boost_regulator_config_regs_tb
  import boost_cfg_pkg::*;
;
  logic clk, rst, en, wr, rd, hit, adapt, cluster, startup, dim, raise;
  logic lower;
  logic [7:0] addr, wdata, rdata, q;
  loop_cfg_t lc;
  timing_cfg_t tc;
  target_t tg;
  int errors, compares;
  logic [23:0] rows [6] = '{24'h73ff3f, 24'h732a2a, 24'h74a5a5,
    24'h75fff7, 24'h725500, 24'h76aa00};
  logic [8:0] jit [4] = '{9'd0, 9'd300, 9'd60, 9'd30};
  logic [7:0] offt [4] = '{8'd131, 8'd68, 8'd38, 8'd24};
  logic [7:0] blk [4] = '{8'd162, 8'd88, 8'd63, 8'd40};
  logic [4:0] ramp [8] = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd8, 5'd16};
  boost_regulator_config_regs boost_regulator_config_regs_inst (
    .clock_i(clk), .reset_i(rst), .clk_en_i(en), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_hit_o(hit), .adaptive_voltage_enable_i(adapt),
    .all_cluster_mode_i(cluster), .startup_i(startup), .dim_cycle_i(dim),
    .raise_req_i(raise), .lower_req_i(lower), .loop_cfg_o(lc),
    .timing_cfg_o(tc), .target_o(tg));
  host_model host_model_inst (.clock_i(clk), .reg_rdata_i(rdata),
    .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
  task automatic check(input string n, input logic [15:0] e,
                       input logic [15:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Dim pulses are spaced so each one is seen alone by the pacer.
  task automatic dims(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      dim = 1'b1;
      @(posedge clk);
      #1;
      dim = 1'b0;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    conclude();
  end
  initial begin
    logic [1:0] c;
    rst = 1'b1;
    en = 1'b1;
    adapt = 1'b0;
    cluster = 1'b0;
    startup = 1'b0;
    dim = 1'b0;
    raise = 1'b0;
    lower = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (rows[i]) begin
      host_model_inst.access(rows[i][23:16], rows[i][15:8], 1'b1, q);
      host_model_inst.access(rows[i][23:16], 8'h00, 1'b0, q);
      check("readback", 16'(rows[i][7:0]), 16'(q));
    end
    for (int i = 0; i < 8; i++) begin
      c = i[1:0];
      host_model_inst.access(8'h74, {c, c, c, c}, 1'b1, q);
      host_model_inst.access(8'h75, {c, c, 1'b1, i[2:0]}, 1'b1, q);
      repeat (3) @(posedge clk);
      #1;
      check("light", 16'(5'd5 * {3'h0, c} + 5'd5),
            16'(lc.light_load_ua));
      check("jitter", 16'(jit[c]), 16'(lc.jitter_corner_khz));
      check("bypass", 16'(c == 2'h0), 16'(lc.jitter_bypass));
      check("integral", 16'(c) + 16'd1, 16'(lc.integral_factor));
      check("prop", 16'(c) + 16'd1, 16'(lc.proportional_factor));
      check("off", 16'(offt[c]), 16'(tc.off_time_ns));
      check("blank", 16'(blk[c]), 16'(tc.blank_time_ns));
      check("ramp", 16'(ramp[i]), 16'(tc.ramp_cycles));
    end
    host_model_inst.access(8'h75, 8'h01, 1'b1, q);
    host_model_inst.access(8'h73, 8'h3f, 1'b1, q);
    raise = 1'b1;
    dims(4);
    check("fixed", 16'h3f, 16'(tg.target_code));
    check("top mv", 16'd47500, tg.target_mv);
    host_model_inst.access(8'h73, 8'h10, 1'b1, q);
    adapt = 1'b1;
    @(posedge clk);
    #1;
    startup = 1'b1;
    @(posedge clk);
    #1;
    startup = 1'b0;
    dims(1);
    check("one pulse", 16'h10, 16'(tg.target_code));
    dims(1);
    check("two pulses", 16'h11, 16'(tg.target_code));
    cluster = 1'b1;
    dims(2);
    check("cluster", 16'h10, 16'(tg.target_code));
    cluster = 1'b0;
    raise = 1'b0;
    lower = 1'b1;
    dims(2);
    check("lower", 16'h0f, 16'(tg.target_code));
    raise = 1'b1;
    dims(2);
    check("raise wins", 16'h10, 16'(tg.target_code));
    raise = 1'b0;
    lower = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int a = 8'h73; a < 8'h76; a++) begin
      host_model_inst.access(8'(a), 8'h00, 1'b0, q);
      check("reset value", 16'h0, 16'(q));
    end
    check("base mv", 16'd16000, tg.target_mv);
    conclude();
  end
endmodule
bind boost_regulator_config_regs boost_regulator_config_regs_assertions
  chk_inst (.clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_hit_o(reg_hit_o),
  .adaptive_voltage_enable_i(adaptive_voltage_enable_i),
  .all_cluster_mode_i(all_cluster_mode_i), .loop_cfg_o(loop_cfg_o),
  .target_o(target_o));
